//--- design/serial_port_pkg.sv
package serial_port_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TRIG = 8'h04;
   localparam logic [7:0] OFS_TXDATA = 8'h08;
   localparam logic [7:0] OFS_RXDATA = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IFLAG = 8'h14;
   localparam logic [7:0] OFS_IMASK = 8'h18;
   localparam logic [7:0] OFS_DIV = 8'h1C;

   // Control fields, bit 0 is sync_mode
   typedef struct packed {
      logic osc_on;
      logic clk_timer;
      logic par_odd;
      logic par_en;
      logic receive_enable_bit;
      logic transmit_enable_bit;
      logic sync_mode;
   } ctrl_t;

   // Interrupt factor flags, same layout in the mask register
   typedef struct packed {
      logic receive_error_flag;
      logic receive_complete_flag;
      logic tx_done;
   } iflag_t;

   typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_SHIFT} rx_state_t;

   // Values after reset
   localparam ctrl_t CTRL_RST = 7'h00;
   localparam iflag_t IFLAG_RST = 3'h0;
   localparam logic [15:0] DIV_RST = 16'h0004;
   localparam logic [7:0] DATA_RST = 8'h00;

   // Frame lengths in bit times
   localparam logic [3:0] SYNC_BITS = 4'h8;
   localparam logic [3:0] ASYNC_BITS = 4'hA;

endpackage

//--- design/serial_port.sv
`timescale 1ns/1ps
`default_nettype none

module serial_port (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SIN,
   input wire logic TIMER_UFLOW,
   output logic SOUT,
   output logic SCLK_O,
   output logic SCLK_OE,
   output logic OSC_ON,
   output logic IRQ
);
   import serial_port_pkg::*;

   // Parity over a byte, odd selects inverted sense
   function automatic logic par_of(input logic [7:0] d, input logic odd);
      par_of = (^d) ^ odd;
   endfunction

   ctrl_t ctrl;
   iflag_t flags;
   iflag_t mask;
   logic [15:0] div;
   logic [15:0] div_cnt;
   logic [7:0] tx_data;
   logic [7:0] rx_data;
   logic rx_full, st_par, st_frm, st_ovr;
   logic sin_s1, sin_s2, uf_s1, uf_s2, uf_s3;
   logic tx_busy, tx_half;
   logic [3:0] tx_bits;
   logic [10:0] tx_shift;
   rx_state_t rx_state;
   logic rx_half, done_pend;
   logic [3:0] rx_bits;
   logic [10:0] rx_shift;

   // Bus phases; the slave answers with no wait state
   wire setup = PSEL & ~PENABLE;
   wire acc = PSEL & PENABLE & PREADY;
   wire wr = acc & PWRITE;
   wire rd = acc & ~PWRITE;

   // Address decode
   wire hit_ctrl = (PADDR == OFS_CTRL);
   wire hit_trig = (PADDR == OFS_TRIG);
   wire hit_txd = (PADDR == OFS_TXDATA);
   wire hit_rxd = (PADDR == OFS_RXDATA);
   wire hit_stat = (PADDR == OFS_STATUS);
   wire hit_flag = (PADDR == OFS_IFLAG);
   wire hit_mask = (PADDR == OFS_IMASK);
   wire hit_div = (PADDR == OFS_DIV);
   wire mapped = hit_ctrl | hit_trig | hit_txd | hit_rxd | hit_stat | hit_flag | hit_mask | hit_div;

   wire rx_busy = (rx_state != RX_IDLE);

   // Read selection, reserved bits read as zero
   wire [31:0] rd_val =
      hit_ctrl ? {25'h0, ctrl} :
      hit_trig ? {30'h0, rx_busy, tx_busy} :
      hit_txd ? {24'h0, tx_data} :
      hit_rxd ? {24'h0, rx_data} :
      hit_stat ? {26'h0, rx_full, st_ovr, st_frm, st_par, rx_busy, tx_busy} :
      hit_flag ? {29'h0, flags} :
      hit_mask ? {29'h0, mask} :
      hit_div ? {16'h0, div} : 32'h0;

   // A trigger is dropped while busy or while the other way runs in clocked mode
   wire tx_go = wr & hit_trig & PWDATA[0] & ctrl.transmit_enable_bit & ~tx_busy
      & ~(ctrl.sync_mode & rx_busy);
   wire rx_go = wr & hit_trig & PWDATA[1] & ctrl.receive_enable_bit & ~rx_busy
      & ~(ctrl.sync_mode & (tx_busy | PWDATA[0]));

   // Serial time base: half bit per tick from divider, or one tick per timer underflow
   wire osc_tick = ctrl.osc_on & ~ctrl.clk_timer & (div_cnt == div);
   wire tmr_tick = ctrl.clk_timer & uf_s2 & ~uf_s3;
   wire tick = osc_tick | tmr_tick;

   // Receive sampling; clocked mode samples while the shift clock is high
   wire samp = (rx_state == RX_SHIFT) & tick & (rx_half == ctrl.sync_mode);
   wire rx_last = samp & (rx_bits == 4'h1);
   wire [10:0] fw = {sin_s2, rx_shift[10:1]};
   wire [7:0] rx_byte = ctrl.sync_mode ? fw[10:3] : (ctrl.par_en ? fw[8:1] : fw[9:2]);
   wire par_err = ~ctrl.sync_mode & ctrl.par_en & (fw[9] != par_of(fw[8:1], ctrl.par_odd));
   wire frm_err = ~ctrl.sync_mode & ~fw[10];
   wire ovr_err = rx_last & rx_full;

   // Completion waits one tick behind an error, and never follows an overrun
   wire done_set = (rx_last & ~ovr_err & ~par_err & ~frm_err)
      | (done_pend & tick);
   wire err_set = rx_last & (ovr_err | par_err | frm_err);
   wire tx_fin = tx_busy & tick & tx_half & (tx_bits == 4'h1);

   // Hardware sets beat a same-cycle write-one clear
   wire [2:0] flag_clr = (wr & hit_flag) ? PWDATA[2:0] : 3'h0;
   iflag_t next_flags;
   assign next_flags = (flags & ~flag_clr) | {err_set, done_set, tx_fin};
   wire [3:0] tx_len = 4'(ASYNC_BITS + {3'h0, ctrl.par_en});
   // Async frame; without parity the stop level must sit right after the data
   wire [10:0] tx_frame = ctrl.par_en ? {1'h1, par_of(tx_data, ctrl.par_odd), tx_data, 1'h0}
      : {2'h3, tx_data, 1'h0};

   // Bus answer registers
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         PREADY <= 1'h0;
         PRDATA <= 32'h0;
         PSLVERR <= 1'h0;
      end else begin
         PREADY <= setup;
         PRDATA <= (setup & ~PWRITE) ? rd_val : 32'h0;
         PSLVERR <= setup & ~mapped;
      end
   end

   // Two-stage synchronisers for the line and timer underflow
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         sin_s1 <= 1'h1;
         sin_s2 <= 1'h1;
         uf_s1 <= 1'h0;
         uf_s2 <= 1'h0;
         uf_s3 <= 1'h0;
      end else begin
         sin_s1 <= SIN;
         sin_s2 <= sin_s1;
         uf_s1 <= TIMER_UFLOW;
         uf_s2 <= uf_s1;
         uf_s3 <= uf_s2;
      end
   end

   // Software registers; the oscillator enable starts off
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ctrl <= CTRL_RST;
         mask <= IFLAG_RST;
         div <= DIV_RST;
         tx_data <= DATA_RST;
      end else begin
         if (wr & hit_ctrl) begin
            ctrl <= ctrl_t'(PWDATA[6:0]);
            if (ctrl.transmit_enable_bit | ctrl.receive_enable_bit) begin
               ctrl.sync_mode <= ctrl.sync_mode;
            end
         end
         if (wr & hit_mask) begin
            mask <= iflag_t'(PWDATA[2:0]);
         end
         if (wr & hit_div) begin
            div <= PWDATA[15:0];
         end
         if (wr & hit_txd) begin
            tx_data <= PWDATA[7:0];
         end
      end
   end

   // Divider runs only while the oscillator is on
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         div_cnt <= 16'h0;
      end else begin
         div_cnt <= (osc_tick | ~ctrl.osc_on) ? 16'h0 : 16'(div_cnt + 16'h1);
      end
   end

   // Transmitter: each bit spans two ticks, LSB first
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         tx_busy <= 1'h0;
         tx_half <= 1'h0;
         tx_bits <= 4'h0;
         tx_shift <= 11'h7FF;
      end else if (tx_go) begin
         tx_busy <= 1'h1;
         tx_half <= 1'h0;
         if (ctrl.sync_mode) begin
            tx_shift <= {3'h7, tx_data};
            tx_bits <= SYNC_BITS;
         end else begin
            tx_shift <= tx_frame;
            tx_bits <= tx_len;
         end
      end else if (tx_busy & tick) begin
         tx_half <= ~tx_half;
         if (tx_half) begin
            tx_shift <= {1'h1, tx_shift[10:1]};
            tx_bits <= 4'(tx_bits - 4'h1);
            if (tx_bits == 4'h1) begin
               tx_busy <= 1'h0;
            end
         end
      end
   end

   // Receiver: hunts for a start bit in async mode, shifts at once in clocked mode
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         rx_state <= RX_IDLE;
         rx_half <= 1'h0;
         rx_bits <= 4'h0;
         rx_shift <= 11'h0;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               if (rx_go) begin
                  rx_state <= ctrl.sync_mode ? RX_SHIFT : RX_HUNT;
                  rx_half <= 1'h0;
                  rx_bits <= ctrl.sync_mode ? SYNC_BITS : tx_len;
               end
            end
            RX_HUNT: begin
               if (!sin_s2) begin
                  rx_state <= RX_SHIFT;
                  rx_half <= 1'h0;
               end
            end
            default: begin
               if (tick) begin
                  rx_half <= ~rx_half;
               end
               if (samp) begin
                  rx_shift <= fw;
                  rx_bits <= 4'(rx_bits - 4'h1);
                  if (rx_bits == 4'h1) begin
                     rx_state <= RX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Received data and error status; a full buffer refuses the new byte
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         rx_data <= DATA_RST;
         rx_full <= 1'h0;
         st_par <= 1'h0;
         st_frm <= 1'h0;
         st_ovr <= 1'h0;
         done_pend <= 1'h0;
      end else begin
         if (rx_last) begin
            st_par <= par_err;
            st_frm <= frm_err;
            st_ovr <= ovr_err;
         end
         if (rx_last & ~ovr_err) begin
            rx_data <= rx_byte;
            rx_full <= 1'h1;
         end else if (rd & hit_rxd) begin
            rx_full <= 1'h0;
         end
         if (rx_last & ~ovr_err & (par_err | frm_err)) begin
            done_pend <= 1'h1;
         end else if (tick) begin
            done_pend <= 1'h0;
         end
      end
   end

   // Flags, interrupt level and line pins
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         flags <= IFLAG_RST;
         IRQ <= 1'h0;
         SOUT <= 1'h1;
         SCLK_O <= 1'h1;
         SCLK_OE <= 1'h0;
      end else begin
         flags <= next_flags;
         IRQ <= |(next_flags & mask);
         SOUT <= tx_busy ? tx_shift[0] : 1'h1;
         SCLK_OE <= ctrl.sync_mode & (tx_busy | rx_busy);
         SCLK_O <= ~(ctrl.sync_mode & ((tx_busy & ~tx_half)
            | ((rx_state == RX_SHIFT) & ~rx_half)));
      end
   end

   assign OSC_ON = ctrl.osc_on;

endmodule

`default_nettype wire

//--- sim/serial_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_properties (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic SCLK_O,
   input wire logic SCLK_OE,
   input wire logic OSC_ON,
   input wire logic IRQ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // Bus phase decode
   wire setup = PSEL && !PENABLE;
   wire wr = PSEL && PENABLE && PREADY && PWRITE;
   // Bus answers with zero wait states
   a_ready_next: assert property (setup |=> PREADY) else $error("no ready");
   a_ready_once: assert property (PREADY |=> !PREADY) else $error("ready held");
   a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("stray rdata");
   a_err_unmap: assert property (setup && PADDR > 8'h1C |=> PSLVERR) else $error("no err");
   a_err_mapped: assert property (setup && PADDR <= 8'h1C && PADDR[1:0] == 2'h0
      |=> !PSLVERR) else $error("false err");
   a_osc_write: assert property (wr && PADDR == 8'h00 |=> OSC_ON == $past(PWDATA[6]))
      else $error("osc enable");
   // Checked during reset too, so a mid-run reset is caught
   a_osc_reset: assert property (@(posedge CLK) disable iff (1'b0) !RST_B |=> !OSC_ON)
      else $error("osc on after reset");
   a_irq_masked: assert property (wr && PADDR == 8'h18 && PWDATA[2:0] == 3'h0 |=> ##1 !IRQ)
      else $error("irq while masked");
   a_sclk_idle: assert property (!SCLK_OE |-> SCLK_O) else $error("shift clock idle");
   // Main scenarios reached
   c_err: cover property (PSLVERR);
   c_irq: cover property ($rose(IRQ));
   c_sync: cover property ($rose(SCLK_OE));
endmodule
`default_nettype wire

//--- sim/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Far-end async sender; line idles high
module serial_peer #(parameter int BIT = 100) (
   input wire logic clk,
   output logic sin
);
   initial sin = 1'b1;
   // Start 0, n bits LSB first (parity as bit 8), stop level chosen to force framing faults
   task automatic send(input logic [8:0] b, input int n, input logic stop);
      logic [10:0] f;
      f = {1'b1, b, 1'b0};
      f[n + 1] = stop;
      for (int i = 0; i < n + 2; i++) begin
         sin <= f[i];
         repeat (BIT) @(posedge clk);
      end
      sin <= 1'b1;
   endtask
endmodule
`default_nettype wire

//--- sim/tb_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_serial_port;
   import serial_port_pkg::*;
   logic CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic TIMER_UFLOW = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, SIN, SOUT, SCLK_O, SCLK_OE, OSC_ON, IRQ, er;
   int miscompares = 0, n_tests = 0;
   int n_fall = 0;
   localparam logic [7:0] BYT [3] = '{8'h3C, 8'h5A, 8'h81};
   localparam logic [31:0] FLG [3] = '{32'h2, 32'h4, 32'h4};
   localparam logic [31:0] FLG2 [3] = '{32'h2, 32'h4, 32'h6};
   always #2.5 CLK = ~CLK;
   // Timer underflow source: a rising edge every 50 cycles, one serial tick each
   always begin
      repeat (25) @(posedge CLK);
      TIMER_UFLOW <= ~TIMER_UFLOW;
   end
   // Falling shift-clock edges, one per clocked bit
   always @(negedge SCLK_O) n_fall++;
   serial_port i_dut (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .SIN, .TIMER_UFLOW, .SOUT, .SCLK_O, .SCLK_OE, .OSC_ON, .IRQ);
   serial_peer #(.BIT(100)) i_peer (.clk(CLK), .sin(SIN));
   // One bus transfer; holds the request until ready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      // No wait-state limit here: only the watchdog ends a hung transfer
      do begin @(posedge CLK); end while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // Bounded wait for any of the given flags
   task automatic poll(input logic [31:0] m);
      int n;
      n = 0;
      do begin xfer(0, OFS_IFLAG, 0); n++; end while ((rd & m) == 0 && n < 900);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog: run needs well under a quarter of this
   initial begin
      #200000;
      miscompares++;
      print_verdict;
   end
   initial begin
      int i;
      logic [9:0] f;
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      // Reset values and an unmapped address
      `CHK(OSC_ON, 1'b0)
      xfer(0, OFS_CTRL, 0);
      `CHK(rd, 32'h0)
      xfer(0, OFS_DIV, 0);
      `CHK(rd, 32'h4)
      xfer(0, 8'h20, 0);
      `CHK({er, rd}, 33'h100000000)
      xfer(1, OFS_IMASK, 32'h0);
      $display("test reset done");
      // Async transmit at 100 cycles per bit (divider 49), line checked bit by bit
      xfer(1, OFS_DIV, 32'h31);
      xfer(1, OFS_CTRL, 32'h46);
      // The modelled oscillator runs at once; a real one needs milliseconds here
      repeat (20) @(posedge CLK);
      xfer(1, OFS_TXDATA, 32'hA5);
      xfer(1, OFS_TRIG, 32'h1);
      i = 0;
      while (SOUT !== 1'b0 && i < 200) begin @(posedge CLK); i++; end
      repeat (50) @(posedge CLK);
      f = {1'b1, 8'hA5, 1'b0};
      for (i = 0; i < 10; i++) begin `CHK(SOUT, f[i]) repeat (100) @(posedge CLK); end
      poll(32'h1);
      `CHK(rd, 32'h1)
      `CHK(IRQ, 1'b0)
      xfer(1, OFS_IMASK, 32'h1);
      repeat (2) @(posedge CLK);
      `CHK(IRQ, 1'b1)
      xfer(1, OFS_IFLAG, 32'h1);
      xfer(0, OFS_IFLAG, 0);
      `CHK({IRQ, rd}, 33'h0)
      $display("test transmit done");
      // Good frame, overrun (byte left unread), framing error
      for (i = 0; i < 3; i++) begin
         xfer(1, OFS_TRIG, 32'h2);
         fork
            i_peer.send({1'b0, BYT[i]}, 8, i != 2);
            poll(32'h6);
         join
         `CHK(rd, FLG[i])
         // Completion trails an error by one tick, so wait past it before clearing
         repeat (60) @(posedge CLK);
         xfer(0, OFS_IFLAG, 0);
         `CHK(rd, FLG2[i])
         xfer(1, OFS_IFLAG, 32'h7);
         if (i == 1) begin
            xfer(0, OFS_RXDATA, 0);
            `CHK(rd, 32'h3C)
         end
      end
      $display("test receive done");
      // Clocked mode: both triggers at once start transmit only
      xfer(1, OFS_CTRL, 32'h40);
      xfer(1, OFS_CTRL, 32'h41);
      xfer(1, OFS_CTRL, 32'h47);
      n_fall = 0;
      xfer(1, OFS_TRIG, 32'h3);
      xfer(0, OFS_TRIG, 0);
      `CHK({SCLK_OE, rd}, {1'b1, 32'h1})
      xfer(1, OFS_CTRL, 32'h46);
      xfer(0, OFS_CTRL, 0);
      `CHK(rd, 32'h47)
      poll(32'h1);
      `CHK(rd, 32'h1)
      `CHK(n_fall, 8)
      $display("test clocked done");
      // Mid-run reset, then a timer-clocked receive with a parity fault
      RST_B <= 1'b0;
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      `CHK({OSC_ON, IRQ}, 2'h0)
      xfer(0, OFS_CTRL, 0);
      `CHK(rd, 32'h0)
      xfer(1, OFS_CTRL, 32'h2C);
      xfer(1, OFS_TRIG, 32'h2);
      fork
         i_peer.send({1'b1, 8'h81}, 9, 1'b1);
         poll(32'h6);
      join
      `CHK(rd, 32'h4)
      repeat (60) @(posedge CLK);
      xfer(0, OFS_IFLAG, 0);
      `CHK(rd, 32'h6)
      xfer(1, OFS_IFLAG, 32'h7);
      xfer(0, OFS_STATUS, 0);
      `CHK(rd, 32'h24)
      xfer(0, OFS_RXDATA, 0);
      `CHK(rd, 32'h81)
      $display("test timer parity done");
      print_verdict;
   end
endmodule
bind serial_port serial_port_properties i_props (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE,
   .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SCLK_O, .SCLK_OE, .OSC_ON, .IRQ);
`default_nettype wire
